// [watchdog_regs.svh]
// Register map, field positions, reset values and timing counts of the digital watchdog.
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

`define WDOG_CTRL_ADDR 8'hd8
`define WDOG_CTRL_RESET 8'hfe
`define WDOG_ACT_POS 0
`define WDOG_SR_POS 1
`define WDOG_COUNT_MSB_POS 2
`define WDOG_COUNT_LSB_POS 7
`define WDOG_COUNT_RESET 7'h7f
`define WDOG_SR_FALL_COUNT 7'h40
`define WDOG_PRESCALE_CYCLES 3072
`define WDOG_GUARD_INSTR 28
`define WDOG_STAB_CYCLES 4096

`endif

// [watchdog_pkg.sv]
// Types shared by the digital watchdog design.
package watchdog_pkg;

   typedef enum logic [1:0] {
      run_st,
      wait_st,
      stop_st,
      reset_st
   } cpu_mode_e;

   typedef logic [6:0] count_t;

endpackage

// [digital_watchdog_timer.sv]
// Digital watchdog: reloadable 7-bit downcounter with activation, software reset and STOP control.
`include "watchdog_regs.svh"

module digital_watchdog_timer #(
   parameter bit HW_ACTIVATION = 1'b0,
   parameter bit EXT_STOP_CTRL = 1'b0,
   parameter int PRESCALE_CYCLES = `WDOG_PRESCALE_CYCLES,
   parameter int GUARD_INSTR = `WDOG_GUARD_INSTR,
   parameter int STAB_CYCLES = `WDOG_STAB_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   input wire logic stop_exec,
   input wire logic nmi_pin,
   input wire logic wake_irq,
   input wire logic instr_retire,
   output logic mcu_reset_req,
   output logic stop_mode,
   output logic wait_mode,
   output logic watchdog_active
);

   ////////////////////////////////////////////////////////////////////////////
   // State.

   watchdog_pkg::cpu_mode_e mode_q;
   watchdog_pkg::cpu_mode_e mode_d;
   watchdog_pkg::count_t cnt_q;
   watchdog_pkg::count_t cnt_d;
   logic active_q;
   logic active_d;
   logic [11:0] presc_q;
   logic [11:0] presc_d;
   logic [4:0] guard_q;
   logic [4:0] guard_d;
   logic pending_q;
   logic pending_d;
   logic [12:0] stab_q;
   logic [12:0] stab_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic reset_req_q;
   logic stop_q;
   logic wait_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode.

   wire addr_hit = (bus_addr == `WDOG_CTRL_ADDR);
   wire write_hit = bus_wr & addr_hit;
   wire read_hit = bus_rd & addr_hit;
   wire in_reset = (mode_q == watchdog_pkg::reset_st);

   // Register bit 7 carries the counter LSB, bit 2 the counter MSB of the six count bits.
   wire watchdog_pkg::count_t write_count = {
      bus_wdata[`WDOG_SR_POS],
      bus_wdata[2],
      bus_wdata[3],
      bus_wdata[4],
      bus_wdata[5],
      bus_wdata[6],
      bus_wdata[7]
   };

   wire [7:0] reg_view = {
      cnt_q[0],
      cnt_q[1],
      cnt_q[2],
      cnt_q[3],
      cnt_q[4],
      cnt_q[5],
      cnt_q[6],
      active_q
   };

   ////////////////////////////////////////////////////////////////////////////
   // Activation.

   // Software may only set the bit; hardware activation holds it high.
   wire write_sets_active = write_hit & bus_wdata[`WDOG_ACT_POS];
   wire becomes_active = ~active_q & write_sets_active;

   assign active_d = in_reset ? HW_ACTIVATION :
      (HW_ACTIVATION | active_q | write_sets_active);

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler and counter.

   // The counter holds still in real STOP and while the reset is being issued.
   wire frozen = (mode_q == watchdog_pkg::stop_st) | in_reset;
   wire presc_end = (presc_q == 12'(PRESCALE_CYCLES - 1));
   wire tick = presc_end & ~frozen;
   wire watchdog_pkg::count_t cnt_dec = cnt_q - 7'h01;

   always_comb begin
      if (in_reset | write_hit) begin
         presc_d = 12'h000;
      end else if (frozen) begin
         presc_d = presc_q;
      end else if (presc_end) begin
         presc_d = 12'h000;
      end else begin
         presc_d = presc_q + 12'h001;
      end
   end

   always_comb begin
      if (in_reset) begin
         cnt_d = `WDOG_COUNT_RESET;
      end else if (write_hit) begin
         cnt_d = write_count;
      end else if (tick) begin
         cnt_d = cnt_dec;
      end else begin
         cnt_d = cnt_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset sources.

   // The timeout is the fall of the SR position while counting down, only when active.
   wire count_timeout = active_q & tick & ~write_hit & (cnt_q == `WDOG_SR_FALL_COUNT);

   // Writing SR low in RUN or WAIT resets at once whenever the watchdog is, or is being, activated; in STOP it is ignored.
   wire sr_write_reset = write_hit & ~bus_wdata[`WDOG_SR_POS] &
      (active_q | bus_wdata[`WDOG_ACT_POS] | HW_ACTIVATION);

   wire guard_done = (guard_q == 5'(GUARD_INSTR));

   // A timeout inside the guard window waits until enough instructions have run.
   wire fire_reset = ~in_reset & (sr_write_reset |
      (guard_done & (count_timeout | pending_q)));

   always_comb begin
      if (in_reset | becomes_active) begin
         guard_d = 5'h00;
      end else if (instr_retire & ~guard_done & active_q) begin
         guard_d = guard_q + 5'h01;
      end else begin
         guard_d = guard_q;
      end
   end

   always_comb begin
      if (in_reset | fire_reset) begin
         pending_d = 1'b0;
      end else if (count_timeout) begin
         pending_d = 1'b1;
      end else begin
         pending_d = pending_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // CPU mode sequencing.

   // Real STOP when disabled, or when external control sees NMI high.
   wire real_stop = ~active_q | (EXT_STOP_CTRL & nmi_pin);
   wire stab_end = (stab_q == 13'(STAB_CYCLES - 1));

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         watchdog_pkg::run_st: begin
            if (fire_reset) begin
               mode_d = watchdog_pkg::reset_st;
            end else if (stop_exec & real_stop) begin
               mode_d = watchdog_pkg::stop_st;
            end else if (stop_exec) begin
               mode_d = watchdog_pkg::wait_st;
            end
         end
         watchdog_pkg::wait_st: begin
            if (fire_reset) begin
               mode_d = watchdog_pkg::reset_st;
            end else if (wake_irq) begin
               mode_d = watchdog_pkg::run_st;
            end
         end
         watchdog_pkg::stop_st: begin
            if (wake_irq) begin
               mode_d = watchdog_pkg::run_st;
            end
         end
         watchdog_pkg::reset_st: begin
            if (stab_end) begin
               mode_d = watchdog_pkg::run_st;
            end
         end
         default: begin
            mode_d = watchdog_pkg::run_st;
         end
      endcase
   end

   assign stab_d = (in_reset & ~stab_end) ? stab_q + 13'h0001 : 13'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Read data.

   // Unmapped addresses read as zero; the value appears the cycle after the strobe.
   assign rdata_d = read_hit ? reg_view : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Flip-flops.

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= watchdog_pkg::run_st;
      end else begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= `WDOG_COUNT_RESET;
         active_q <= HW_ACTIVATION;
      end else begin
         cnt_q <= cnt_d;
         active_q <= active_d;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         presc_q <= 12'h000;
         guard_q <= 5'h00;
         pending_q <= 1'b0;
      end else begin
         presc_q <= presc_d;
         guard_q <= guard_d;
         pending_q <= pending_d;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stab_q <= 13'h0000;
         rdata_q <= 8'h00;
      end else begin
         stab_q <= stab_d;
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reset_req_q <= 1'b0;
         stop_q <= 1'b0;
         wait_q <= 1'b0;
      end else begin
         reset_req_q <= (mode_d == watchdog_pkg::reset_st);
         stop_q <= (mode_d == watchdog_pkg::stop_st);
         wait_q <= (mode_d == watchdog_pkg::wait_st);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign bus_rdata = rdata_q;
   assign mcu_reset_req = reset_req_q;
   assign stop_mode = stop_q;
   assign wait_mode = wait_q;
   assign watchdog_active = active_q;

endmodule

// [watchdog_checker_properties.sv]
// Concurrent checks of the watchdog register port, reset request and STOP/WAIT mode sequencing.
module watchdog_checker #(
   parameter bit EXT_STOP_CTRL = 1'b0
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic stop_exec,
   input wire logic nmi_pin,
   input wire logic wake_irq,
   input wire logic instr_retire,
   input wire logic mcu_reset_req,
   input wire logic stop_mode,
   input wire logic wait_mode,
   input wire logic watchdog_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire wr_hit = bus_wr && bus_addr == 8'hd8 && !mcu_reset_req;
   wire run = !stop_mode && !wait_mode && !mcu_reset_req;
   unmapped_read_a: assert property (bus_rd && bus_addr != 8'hd8 |=> bus_rdata == 8'h00)
      else $error("unmapped read not zero");
   sw_reset_a: assert property (wr_hit && !bus_wdata[1] && (watchdog_active || bus_wdata[0]) |-> ##[1:2] mcu_reset_req)
      else $error("software reset missing");
   activate_a: assert property (wr_hit && bus_wdata[0] && bus_wdata[1] |=> watchdog_active)
      else $error("activation missing");
   active_sticky_a: assert property (watchdog_active && !mcu_reset_req |=> watchdog_active)
      else $error("activation bit cleared");
   req_hold_a: assert property ($rose(mcu_reset_req) |-> mcu_reset_req [*8] ##1 !mcu_reset_req)
      else $error("reset request length wrong");
   stop_idle_a: assert property (run && stop_exec && !watchdog_active |=> stop_mode)
      else $error("stop not entered");
   stop_nmi_a: assert property (run && stop_exec && EXT_STOP_CTRL && nmi_pin |=> stop_mode)
      else $error("stop with nmi high not entered");
   stop_wait_a: assert property (run && stop_exec && watchdog_active && !nmi_pin |=> wait_mode && !stop_mode)
      else $error("stop not run as wait");
   wake_a: assert property (stop_mode && wake_irq && !mcu_reset_req |=> !stop_mode)
      else $error("no wake from stop");
   mode_excl_a: assert property (!(stop_mode && wait_mode))
      else $error("stop and wait together");
   cover property (wr_hit && !bus_wdata[1]);
   cover property (stop_mode && wake_irq);
   cover property (wait_mode && wake_irq);
endmodule
bind digital_watchdog_timer watchdog_checker #(.EXT_STOP_CTRL(EXT_STOP_CTRL)) u_chk (.sys_clk(sys_clk),
   .reset_n(reset_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
   .bus_rdata(bus_rdata), .stop_exec(stop_exec), .nmi_pin(nmi_pin), .wake_irq(wake_irq),
   .instr_retire(instr_retire), .mcu_reset_req(mcu_reset_req), .stop_mode(stop_mode),
   .wait_mode(wait_mode), .watchdog_active(watchdog_active));

// [cpu_side_model.sv]
// Model of the CPU side: instruction pulses and the board level of the NMI pin.
module cpu_side_model (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic stop_mode,
   input wire logic wait_mode,
   input wire logic mcu_reset_req,
   input wire logic nmi_low_req,
   output logic instr_retire,
   output logic nmi_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // The pin rests high and is pulled low only on request.
   assign nmi_pin = !nmi_low_req;
   initial instr_retire = 1'b0;
   // One instruction retires each cycle while the core runs.
   always @(negedge sys_clk) begin
      instr_retire <= reset_n && !stop_mode && !wait_mode && !mcu_reset_req;
   end
endmodule

// [testbench.sv]
// Self-checking bench of the digital watchdog.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, reset_n = 0, bus_wr = 0, bus_rd = 0, stop_exec = 0, wake_irq = 0, nmi_low = 0;
   logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, rv;
   logic instr_retire, nmi_pin, mcu_reset_req, stop_mode, wait_mode, watchdog_active;
   int errors = 0, checks = 0, cyc = 0, n;
   always #4 sys_clk = ~sys_clk;
   digital_watchdog_timer #(.EXT_STOP_CTRL(1'b1), .PRESCALE_CYCLES(16), .STAB_CYCLES(8)) u_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .stop_exec(stop_exec), .nmi_pin(nmi_pin),
      .wake_irq(wake_irq), .instr_retire(instr_retire), .mcu_reset_req(mcu_reset_req),
      .stop_mode(stop_mode), .wait_mode(wait_mode), .watchdog_active(watchdog_active));
   cpu_side_model u_cpu (.sys_clk(sys_clk), .reset_n(reset_n), .stop_mode(stop_mode),
      .wait_mode(wait_mode), .mcu_reset_req(mcu_reset_req), .nmi_low_req(nmi_low),
      .instr_retire(instr_retire), .nmi_pin(nmi_pin));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] d);
      @(negedge sys_clk);
      bus_wr = 1;
      bus_addr = 8'hd8;
      bus_wdata = d;
      @(negedge sys_clk);
      bus_wr = 0;
   endtask
   task automatic rd(logic [7:0] a);
      @(negedge sys_clk);
      bus_rd = 1;
      bus_addr = a;
      @(negedge sys_clk);
      bus_rd = 0;
      rv = bus_rdata;
   endtask
   task automatic pulse(ref logic s);
      @(negedge sys_clk);
      s = 1;
      @(negedge sys_clk);
      s = 0;
   endtask
   // Counts cycles until the reset request, then checks that it has ended eight cycles later and reads the register.
   task automatic wait_req(int lim);
      n = 0;
      while (!mcu_reset_req && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      chk("req_seen", 1, mcu_reset_req);
      for (int i = 0; i < 8; i++) @(negedge sys_clk);
      chk("req_len", 0, mcu_reset_req);
      rd(8'hd8);
      chk("after_reset", 8'hfe, rv);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      rd(8'hd8);
      chk("reset_reg", 8'hfe, rv);
      chk("reset_active", 0, watchdog_active);
      rd(8'hd9);
      chk("unmapped", 8'h00, rv);
   endtask
   task automatic t_timer();
      wr(8'h02);
      repeat (20) @(negedge sys_clk);
      rd(8'hd8);
      chk("timer_tick", 8'hfc, rv);
      chk("timer_noreset", 0, mcu_reset_req);
   endtask
   task automatic t_stop_idle();
      nmi_low = 1;
      pulse(stop_exec);
      chk("idle_stop", 1, stop_mode);
      pulse(wake_irq);
      chk("idle_wake", 0, stop_mode);
      nmi_low = 0;
   endtask
   task automatic t_sticky_swreset();
      wr(8'hff);
      wr(8'hfe);
      rd(8'hd8);
      chk("sticky", 8'hff, rv);
      wr(8'hfd);
      chk("sw_reset_fast", 1, mcu_reset_req);
      wait_req(4);
   endtask
   // Count value 1 with C and SR set: two prescaler periods to the timeout.
   task automatic t_timeout();
      wr(8'h83);
      wait_req(200);
      chk("timeout_cycles", 8'd32, n[7:0]);
   endtask
   task automatic t_stop_wd();
      wr(8'hff);
      pulse(stop_exec);
      chk("stop_nmi_high", 1, stop_mode);
      repeat (40) @(negedge sys_clk);
      rd(8'hd8);
      chk("frozen", 8'hff, rv);
      pulse(wake_irq);
      chk("woken", 0, stop_mode);
      nmi_low = 1;
      pulse(stop_exec);
      chk("as_wait", 1, wait_mode);
      pulse(wake_irq);
      nmi_low = 0;
      wr(8'hfd);
      wait_req(4);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (10) @(negedge sys_clk);
      reset_n = 1;
      t_reset_values();
      t_timer();
      t_stop_idle();
      t_sticky_swreset();
      t_timeout();
      t_stop_wd();
      give_verdict();
   end
endmodule
